// *** wepa_pkg.sv ***
// package for the word eprom host controller
// assumes a 100 MHz clock; the memory device sits outside on pins
package wepa_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int CLK_NS = 10;
    // read and programming timing of the fastest grade
    localparam int T_ACC_NS = 150;
    localparam int T_OE_NS  = 60;
    localparam int T_DF_NS  = 35;
    localparam int T_SU_NS  = 2000;
    localparam int T_PW_LONG_NS  = 1000000;
    localparam int T_PW_FAST_NS  = 100000;
    // least times round up
    localparam int CYC_ADDR = (T_ACC_NS - T_OE_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_OE   = (T_OE_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_DF   = (T_DF_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_SU   = (T_SU_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_PW_LONG = T_PW_LONG_NS / CLK_NS;
    localparam int CYC_PW_FAST = T_PW_FAST_NS / CLK_NS;
    localparam int CNT_W = 20;
    localparam logic [DATA_W-1:0] BLANK_WORD = 16'hffff;
    localparam int SIG_SEL_BIT = 9;
    localparam int ID_SEL_BIT  = 0;
    localparam logic [1:0] OP_READ = 2'h0;
    localparam logic [1:0] OP_PROG = 2'h1;
    localparam logic [1:0] OP_ID   = 2'h2;
    typedef enum logic [6:0] {
        WEPA_IDLE  = 7'h01,
        WEPA_SETUP = 7'h02,
        WEPA_ADDR  = 7'h04,
        WEPA_OE    = 7'h08,
        WEPA_PULSE = 7'h10,
        WEPA_HOLD  = 7'h20,
        WEPA_FLOAT = 7'h40
    } wepa_state_e;
endpackage

// *** wepa_counter.sv ***
// wepa_counter: loadable down-counter that times pin phases
// assumes one clock; load has priority over counting
`timescale 1ns/1ns
`default_nettype none
module wepa_counter #(
    parameter int W = 20
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    output var  logic         done
);
    logic [W-1:0] cnt_ff;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_ff <= '0;
        end else if (load) begin
            cnt_ff <= load_val;
        end else if (cnt_ff != '0) begin
            cnt_ff <= cnt_ff - 1'b1;
        end
    end
    // done does not look at load, so a caller may reload on done without a loop
    assign done = (cnt_ff == '0);
endmodule
`default_nettype wire

// *** wepa_host.sv ***
// wepa_host: programmer/reader that drives a 64K x 16 word eprom on its pins
// assumes the supply switches follow prog_supply_on and signature_high_voltage outputs
//
// Behaviour
// (R1) device drives the stored word when chip select and output enable low
// (R2) array is 65,536 words of 16 bits on sixteen address lines
// (R3) select low, output enable high: data lines floated, no programming
// (R4) chip select high gives standby with floated outputs
// (R5) address stable acc minus oe, then data valid oe after enable falls
// (R6) identification read holds signature line at elevated voltage
// (R7) id read with id select low returns maker code
// (R8) id read with id select high returns part-type code
// (R9) blank reads all ones; programming only clears bits
// (R10) strobe low with supplies, select low, enable high writes zeros
// (R11) verify: supplies on, select and enable low, strobe high
// (R12) chip select high blocks programming under supplies
// (R13) long pulse held low 0.95 to 1.05 ms
// (R14) fast pulse held low 100 us, never beyond 105 us
// (R15) strobe ignored in read, disable and standby
// (R16) repeat strobe and verify until word matches, then next address; the host gives up after MAX_TRIES pulses and sets rsp_fail
`timescale 1ns/1ns
`default_nettype none
module wepa_host
    import wepa_pkg::*;
#(
    parameter int          MAX_TRIES   = 25,
    parameter int          PW_LONG_CYC = wepa_pkg::CYC_PW_LONG,
    parameter int          PW_FAST_CYC = wepa_pkg::CYC_PW_FAST
) (
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    input  wire logic                      req_valid,
    input  wire logic [1:0]                req_op,
    input  wire logic                      req_fast,
    input  wire logic [wepa_pkg::ADDR_W-1:0] req_addr,
    input  wire logic [wepa_pkg::DATA_W-1:0] req_wdata,
    output logic                           req_ready,
    output logic                           rsp_valid,
    output logic [wepa_pkg::DATA_W-1:0]    rsp_rdata,
    output logic                           rsp_fail,
    output logic [wepa_pkg::ADDR_W-1:0]    word_address_lines,
    output logic [wepa_pkg::DATA_W-1:0]    word_data_out,
    output logic                           word_data_oe,
    input  wire logic [wepa_pkg::DATA_W-1:0] word_data_lines,
    output logic                           chip_sel_n,
    output logic                           out_en_n,
    output logic                           prog_strobe_n,
    output logic                           prog_supply_on,
    output logic                           signature_high_voltage
);
    import wepa_pkg::*;

    // ==========================================================
    // pin input synchroniser
    logic [DATA_W-1:0] din_meta_ff;
    logic [DATA_W-1:0] din_ff;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            din_meta_ff <= '0;
            din_ff      <= '0;
        end else begin
            din_meta_ff <= word_data_lines;
            din_ff      <= din_meta_ff;
        end
    end

    // ==========================================================
    // phase timer
    wepa_state_e     state_ff;
    logic            tload;
    logic [CNT_W-1:0] tval;
    logic            tdone;
    // two extra cycles cover the input synchroniser delay
    localparam int SYNC_CYC = 2;
    wepa_counter #(.W(CNT_W)) u_timer (
        .clk      (clk),
        .rst_n    (rst_n),
        .load     (tload),
        .load_val (tval),
        .done     (tdone)
    );

    // ==========================================================
    // transfer state
    logic [1:0]        op_ff;
    logic              fast_ff;
    logic [DATA_W-1:0] wdata_ff;
    logic [7:0]        tries_ff;
    logic              verify_ok;
    logic              retry;
    assign verify_ok = (din_ff == wdata_ff);
    // (R16) another pulse while read-back differs and tries remain
    assign retry = (op_ff == OP_PROG) && !verify_ok && (tries_ff < 8'(MAX_TRIES));

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_ff <= WEPA_IDLE;
        end else begin
            case (state_ff)
                WEPA_IDLE: if (req_valid) state_ff <= WEPA_SETUP;
                WEPA_SETUP: if (tdone) state_ff <= (op_ff == OP_PROG) ? WEPA_PULSE : WEPA_ADDR;
                WEPA_ADDR: if (tdone) state_ff <= WEPA_OE;
                WEPA_PULSE: if (tdone) state_ff <= WEPA_HOLD;
                WEPA_HOLD: if (tdone) state_ff <= WEPA_ADDR;
                WEPA_OE: begin
                    if (tdone) begin
                        // (R16) retry through setup: enable high and data driven long before the strobe
                        if (retry) begin
                            state_ff <= WEPA_SETUP;
                        end else begin
                            state_ff <= WEPA_FLOAT;
                        end
                    end
                end
                WEPA_FLOAT: if (tdone) state_ff <= WEPA_IDLE;
                default: state_ff <= WEPA_IDLE;
            endcase
        end
    end

    // timer load on every phase entry except the return to idle
    always_comb begin
        tload = 1'b0;
        tval  = '0;
        case (state_ff)
            WEPA_IDLE: begin
                tload = req_valid;
                tval  = CNT_W'(CYC_SU);
            end
            WEPA_SETUP, WEPA_HOLD: begin
                tload = tdone;
                // (R13) (R14) strobe width per algorithm
                if (state_ff == WEPA_SETUP && op_ff == OP_PROG) begin
                    tval = fast_ff ? CNT_W'(PW_FAST_CYC) : CNT_W'(PW_LONG_CYC);
                end else begin
                    // (R5) address settles acc minus oe first
                    tval = CNT_W'(CYC_ADDR);
                end
            end
            WEPA_ADDR: begin
                tload = tdone;
                tval  = CNT_W'(CYC_OE + SYNC_CYC);
            end
            WEPA_PULSE: begin
                tload = tdone;
                tval  = CNT_W'(CYC_SU);
            end
            WEPA_OE: begin
                tload = tdone;
                tval  = retry ? CNT_W'(CYC_SU) : CNT_W'(CYC_DF);
            end
            default: begin
                tload = 1'b0;
                tval  = '0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            op_ff    <= OP_READ;
            fast_ff  <= 1'b0;
            wdata_ff <= BLANK_WORD;
            tries_ff <= '0;
        end else if (state_ff == WEPA_IDLE && req_valid) begin
            op_ff    <= req_op;
            fast_ff  <= req_fast;
            wdata_ff <= req_wdata;
            tries_ff <= '0;
        end else if (state_ff == WEPA_PULSE && tdone) begin
            tries_ff <= tries_ff + 8'h01;
        end
    end

    // ==========================================================
    // pin drive
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            word_address_lines <= '0;
            signature_high_voltage <= 1'b0;
        end else if (state_ff == WEPA_IDLE && req_valid) begin
            word_address_lines <= req_addr;
            // (R6) signature line raised for identification reads
            signature_high_voltage <= (req_op == OP_ID);
        end else if (state_ff == WEPA_IDLE) begin
            signature_high_voltage <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            chip_sel_n     <= 1'b1;
            out_en_n       <= 1'b1;
            prog_strobe_n  <= 1'b1;
            prog_supply_on <= 1'b0;
            word_data_oe   <= 1'b0;
            word_data_out  <= BLANK_WORD;
        end else begin
            // (R4) standby outside transfers
            chip_sel_n <= (state_ff == WEPA_IDLE && !req_valid) ||
                          (state_ff == WEPA_FLOAT && tdone);
            // (R10) strobe only with enable high and select low
            prog_strobe_n <= !((state_ff == WEPA_SETUP && tdone && op_ff == OP_PROG) ||
                               (state_ff == WEPA_PULSE && !tdone));
            // (R11) verify and reads: enable low after address time
            out_en_n <= !((state_ff == WEPA_ADDR && tdone) ||
                          (state_ff == WEPA_OE && !tdone));
            if (state_ff == WEPA_IDLE && req_valid) begin
                prog_supply_on <= (req_op == OP_PROG);
                word_data_out  <= req_wdata;
            end else if (state_ff == WEPA_FLOAT && tdone) begin
                prog_supply_on <= 1'b0;
            end
            // host drives data only while the device output is off
            word_data_oe <= (op_ff == OP_PROG) &&
                            ((state_ff == WEPA_SETUP) || (state_ff == WEPA_PULSE) ||
                             (state_ff == WEPA_HOLD && !tdone));
        end
    end

    // ==========================================================
    // answer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
            rsp_fail  <= 1'b0;
        end else begin
            req_ready <= (state_ff == WEPA_IDLE && !req_valid) ||
                         (state_ff == WEPA_FLOAT && tdone);
            rsp_valid <= (state_ff == WEPA_OE && tdone && !retry);
            if (state_ff == WEPA_OE && tdone) begin
                rsp_rdata <= din_ff;
                // (R9) program can only clear bits, so a failure is final
                rsp_fail  <= (op_ff == OP_PROG) && !verify_ok;
            end
        end
    end
endmodule
`default_nettype wire

// *** wepa_host_monitor.sv ***
// pin-sequence checks on the eprom host
// assumes a bind onto wepa_host with its pulse parameters
`timescale 1ns/1ns
`default_nettype none
module wepa_host_monitor
    import wepa_pkg::*;
#(
    parameter int PW_LONG_CYC = 40,
    parameter int PW_FAST_CYC = 20
) (
    input wire logic                         clk,
    input wire logic                         rst_n,
    input wire logic                         rsp_valid,
    input wire logic [wepa_pkg::ADDR_W-1:0] word_address_lines,
    input wire logic                         word_data_oe,
    input wire logic                         chip_sel_n,
    input wire logic                         out_en_n,
    input wire logic                         prog_strobe_n,
    input wire logic                         prog_supply_on,
    input wire logic                         signature_high_voltage
);
    localparam int LO_L = PW_LONG_CYC * 95 / 100;
    localparam int HI_L = PW_LONG_CYC * 105 / 100;
    localparam int LO_F = PW_FAST_CYC * 95 / 100;
    localparam int HI_F = PW_FAST_CYC * 105 / 100;
    logic [19:0]        low_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic [19:0]        stab_ff;
    default clocking cb @(posedge clk); endclocking
    // =========================================
    // helper counts
    always_ff @(posedge clk) begin
        low_ff <= (!rst_n || prog_strobe_n) ? 20'h0 : low_ff + 20'h1;
    end
    // saturating, so a long hold never wraps back under the limit
    always_ff @(posedge clk) begin
        addr_ff <= word_address_lines;
        stab_ff <= (!rst_n || word_address_lines != addr_ff) ? 20'h0 : stab_ff + {19'h0, stab_ff != 20'hfffff};
    end
    // =========================================
    // assertions
    property p_reset_idle;
        !rst_n |=> chip_sel_n && out_en_n && prog_strobe_n && !word_data_oe && !prog_supply_on && !rsp_valid;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("pins not idle after reset");
    property p_strobe_mode;
        disable iff (!rst_n) !prog_strobe_n |-> !chip_sel_n && out_en_n && prog_supply_on;
    endproperty
    a_strobe_mode: assert property (p_strobe_mode) else $error("strobe outside program mode");
    property p_strobe_data;
        disable iff (!rst_n) !prog_strobe_n |-> word_data_oe;
    endproperty
    a_strobe_data: assert property (p_strobe_data) else $error("strobe without data driven");
    property p_oe_sel;
        disable iff (!rst_n) !out_en_n |-> !chip_sel_n && !word_data_oe;
    endproperty
    a_oe_sel: assert property (p_oe_sel) else $error("output enable while deselected or driving");
    property p_pulse_width;
        disable iff (!rst_n) $rose(prog_strobe_n) |-> (low_ff >= LO_L && low_ff <= HI_L) || (low_ff >= LO_F && low_ff <= HI_F);
    endproperty
    a_pulse_width: assert property (p_pulse_width) else $error("program pulse width out of range");
    property p_addr_settle;
        disable iff (!rst_n) $fell(out_en_n) |-> stab_ff >= CYC_ADDR;
    endproperty
    a_addr_settle: assert property (p_addr_settle) else $error("address not settled before enable");
    property p_sig_read;
        disable iff (!rst_n) signature_high_voltage |-> !prog_supply_on && prog_strobe_n;
    endproperty
    a_sig_read: assert property (p_sig_read) else $error("signature level outside plain read");
    property p_data_hold;
        disable iff (!rst_n) $rose(prog_strobe_n) |-> (stab_ff > low_ff) ##0 word_data_oe [*8];
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("data or address moved around pulse");
    property p_rsp_sel;
        disable iff (!rst_n) rsp_valid |-> !chip_sel_n;
    endproperty
    a_rsp_sel: assert property (p_rsp_sel) else $error("answer given while deselected");
endmodule
`default_nettype wire

// *** wepa_dev_model.sv ***
// behavioural 64K x 16 eprom on the far side of the host
// assumes a shared clk to time its output delay; undriven lines toggle
`timescale 1ns/1ns
`default_nettype none
module wepa_dev_model
    import wepa_pkg::*;
#(
    parameter logic [15:0] MAKER_CODE = 16'h5a01, // arbitrary value
    parameter logic [15:0] PART_CODE  = 16'h5a02  // arbitrary value
) (
    input wire logic        clk,
    input wire logic [15:0] addr,
    input wire logic [15:0] host_data,
    input wire logic        host_oe,
    input wire logic        cs_n,
    input wire logic        oe_n,
    input wire logic        pgm_n,
    input wire logic        supply_on,
    input wire logic        sig_hv,
    output var logic [15:0] lines
);
    logic [DATA_W-1:0] mem [0:65535];
    logic [DATA_W-1:0] last_ff = '0;
    logic [3:0]        age_ff;
    logic              drive;
    logic [DATA_W-1:0] word;
    initial for (int i = 0; i < 65536; i++) mem[i] = BLANK_WORD;
    always @(posedge clk) begin
        if (supply_on && !cs_n && oe_n && !pgm_n) mem[addr] <= mem[addr] & host_data;
    end
    always @(posedge clk) begin
        age_ff  <= (cs_n || oe_n) ? 4'h0 : age_ff + {3'h0, age_ff != 4'hf};
        last_ff <= lines;
    end
    assign drive = !cs_n && !oe_n && age_ff >= CYC_OE;
    assign word  = sig_hv ? (addr[ID_SEL_BIT] ? PART_CODE : MAKER_CODE) : mem[addr];
    assign lines = host_oe ? host_data : (drive ? word : ~last_ff);
endmodule
`default_nettype wire

// *** wepa_host_tb.sv ***
// self-checking bench for wepa_host against the eprom model
// assumes shortened pulse counts; expectations from a shadow array
`timescale 1ns/1ns
`default_nettype none
`define CHK(what, e, g) begin n_compared++; if ((e) !== (g)) begin fail_count++; \
    $display("CHECK FAILED %s expected %h seen %h", what, e, g); end end
module wepa_host_tb;
    import wepa_pkg::*;
    localparam logic [15:0] MAKER = 16'h5a01; // arbitrary value
    localparam logic [15:0] PART  = 16'h5a02; // arbitrary value
    logic        clk = 0, rst_n = 0, req_valid = 0, req_fast = 0;
    logic [1:0]  req_op = OP_READ;
    logic [15:0] req_addr = 16'h0, req_wdata = 16'h0, a, w;
    logic        req_ready, rsp_valid, rsp_fail, oe, cs_n, oe_n, pgm_n, sup, hv;
    logic [15:0] rsp_rdata, wal, wdo, wdl;
    logic [15:0] shadow [logic [15:0]];
    int          fail_count = 0, n_compared = 0, seed = 34498;
    initial forever #5 clk = ~clk;
    wepa_host #(.MAX_TRIES(3), .PW_LONG_CYC(40), .PW_FAST_CYC(20)) u_wepa_host (.clk(clk), .rst_n(rst_n),
        .req_valid(req_valid), .req_op(req_op), .req_fast(req_fast), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_fail(rsp_fail),
        .word_address_lines(wal), .word_data_out(wdo), .word_data_oe(oe), .word_data_lines(wdl),
        .chip_sel_n(cs_n), .out_en_n(oe_n), .prog_strobe_n(pgm_n), .prog_supply_on(sup),
        .signature_high_voltage(hv));
    wepa_dev_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) u_wepa_dev_model (.clk(clk), .addr(wal),
        .host_data(wdo), .host_oe(oe), .cs_n(cs_n), .oe_n(oe_n), .pgm_n(pgm_n), .supply_on(sup),
        .sig_hv(hv), .lines(wdl));
    function automatic logic [15:0] exp_of(input logic [15:0] x);
        return shadow.exists(x) ? shadow[x] : BLANK_WORD;
    endfunction
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // one request: wait idle, present, hold until taken, await the answer
    task automatic do_op(input logic [1:0] op, input logic fast, input logic [15:0] ad, input logic [15:0] wd);
        int n;
        n = 0;
        do begin @(posedge clk); #1; n++; end while (req_ready !== 1'b1 && n < 100);
        @(posedge clk);
        req_op    <= op;
        req_fast  <= fast;
        req_addr  <= ad;
        req_wdata <= wd;
        req_valid <= 1'b1;
        do begin @(posedge clk); #1; n++; end while (req_ready === 1'b1 && n < 200);
        @(posedge clk);
        req_valid <= 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 6000) begin @(posedge clk); #1; n++; end
        if (n >= 6000) fail_count++;
    endtask
    initial begin
        #200000;
        fail_count++;
        end_of_test();
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            a = (i == 0) ? 16'h0 : (i == 1) ? 16'hffff : 16'($random(seed));
            do_op(OP_READ, 1'b0, a, 16'h0);
            `CHK("blank read", exp_of(a), rsp_rdata)
        end
        for (int i = 0; i < 2; i++) begin
            do_op(OP_ID, 1'b0, 16'(i), 16'h0);
            `CHK("id code", (i == 1) ? PART : MAKER, rsp_rdata)
        end
        // program then read back each word
        for (int i = 0; i < 6; i++) begin
            a = (i == 0) ? 16'h0 : (i == 1) ? 16'hffff : 16'($random(seed));
            w = 16'($random(seed));
            shadow[a] = exp_of(a) & w;
            do_op(OP_PROG, i[0], a, w);
            `CHK("program fail", 1'b0, rsp_fail)
            `CHK("verify word", w, rsp_rdata)
            do_op(OP_READ, 1'b0, a, 16'h0);
            `CHK("read back", shadow[a], rsp_rdata)
        end
        // a cleared bit cannot come back, so verify must give up
        a = 16'h1234 ^ 16'($random(seed));
        w = 16'($random(seed)) & 16'h7fff;
        shadow[a] = exp_of(a) & w;
        do_op(OP_PROG, 1'b1, a, w);
        do_op(OP_PROG, 1'b1, a, w | 16'h8000);
        `CHK("set back refused", 1'b1, rsp_fail)
        do_op(OP_READ, 1'b0, a, 16'h0);
        `CHK("word kept", shadow[a], rsp_rdata)
        end_of_test();
    end
endmodule
bind wepa_host wepa_host_monitor #(.PW_LONG_CYC(PW_LONG_CYC), .PW_FAST_CYC(PW_FAST_CYC)) u_wepa_host_monitor (
    .clk(clk), .rst_n(rst_n), .rsp_valid(rsp_valid), .word_address_lines(word_address_lines),
    .word_data_oe(word_data_oe), .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .prog_strobe_n(prog_strobe_n),
    .prog_supply_on(prog_supply_on), .signature_high_voltage(signature_high_voltage));
`default_nettype wire
